// File: pkg/ofl_map.vh
// constants for the output frequency limiter: register offsets, field positions, reset values
// assumes units of 0.01 Hz for frequencies and 0.1 V for voltages
`ifndef OFL_MAP_VH
`define OFL_MAP_VH
// register byte offsets on the apb slave
`define OFL_UPPER_OFS 12'h000
`define OFL_LOWER_OFS 12'h004
`define OFL_HSPEED_OFS 12'h008
`define OFL_JOG_OFS 12'h00c
`define OFL_START_OFS 12'h010
`define OFL_JUMP1A_OFS 12'h014
`define OFL_JUMP1B_OFS 12'h018
`define OFL_JUMP2A_OFS 12'h01c
`define OFL_JUMP2B_OFS 12'h020
`define OFL_JUMP3A_OFS 12'h024
`define OFL_JUMP3B_OFS 12'h028
`define OFL_BASEF_OFS 12'h02c
`define OFL_BASEF2_OFS 12'h030
`define OFL_BASEV_OFS 12'h034
`define OFL_GROUP_OFS 12'h038
`define OFL_CMD_OFS 12'h03c
`define OFL_STATUS_OFS 12'h040
`define OFL_OUTF_OFS 12'h044
`define OFL_OUTBF_OFS 12'h048
`define OFL_OUTBV_OFS 12'h04c
// command register field positions
`define OFL_CMD_FREQ_LSB 0
`define OFL_CMD_FREQ_MSB 15
`define OFL_CMD_JOG_BIT 16
`define OFL_CMD_START_BIT 17
`define OFL_CMD_STALL_BIT 18
`define OFL_CMD_VALID_BIT 19
// status register field positions
`define OFL_ST_SECOND_BIT 0
`define OFL_ST_UPCLAMP_BIT 1
`define OFL_ST_LOCLAMP_BIT 2
`define OFL_ST_JUMP_BIT 3
`define OFL_ST_WRLOCK_BIT 4
// value limits and reset values, frequencies in 0.01 Hz
`define OFL_F120 16'd12000
`define OFL_F400 16'd40000
`define OFL_F60 16'd6000
`define OFL_V1000 16'd10000
`define OFL_CODE_OFF 16'd9999
`define OFL_CODE_95 16'd8888
`define OFL_UPPER_RST 16'd12000
`define OFL_LOWER_RST 16'h0000
`define OFL_JOG_RST 16'd500
`define OFL_START_RST 16'd50
`define OFL_BASEF_RST 16'd6000
`define OFL_ZERO16 16'h0000
`endif

// File: src/ofl_limiter.v
// output frequency limiter: clamps, jump bands, base frequency and base voltage select
// assumes an apb master on pclk and supply voltage / model straps synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "ofl_map.vh"

module ofl_limiter #(
  parameter FW = 16
)
(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire second_function_input,
  input wire [FW-1:0] supply_voltage,
  input wire single_phase_100v,
  output reg [FW-1:0] out_freq,
  output reg [FW-1:0] out_base_freq,
  output reg [FW-1:0] out_base_voltage,
  output reg second_set_active
);

  ////////////////////////////////////////////////////////////////////////////
  // settings and command registers
  reg [FW-1:0] upper_freq_limit_reg;
  reg [FW-1:0] lower_freq_limit_reg;
  reg [FW-1:0] high_speed_upper_limit_reg;
  reg [FW-1:0] jog_freq_setting_reg;
  reg [FW-1:0] starting_freq_setting_reg;
  reg [FW-1:0] jump_band_bounds_reg [0:5];
  reg [FW-1:0] primary_base_freq_reg;
  reg [FW-1:0] second_base_freq_reg;
  reg [FW-1:0] base_voltage_setting_reg;
  reg [FW-1:0] user_group_read_select_reg;
  reg [FW-1:0] cmd_freq_reg;
  reg cmd_jog_reg;
  reg cmd_start_reg;
  reg cmd_stall_reg;
  reg cmd_valid_reg;
  reg up_clamp_reg;
  reg lo_clamp_reg;
  reg jumped_reg;
  integer i;

  // clamp a write value into a legal range; out of range writes saturate
  function [FW-1:0] fit;
    input [31:0] v;
    input [FW-1:0] lo;
    input [FW-1:0] hi;
    begin
      if (v[31:FW] != {(32-FW){1'b0}} || v[FW-1:0] > hi)
        fit = hi;
      else if (v[FW-1:0] < lo)
        fit = lo;
      else
        fit = v[FW-1:0];
    end
  endfunction

  // accept a frequency setting or its disable code
  function [FW-1:0] fit_code;
    input [31:0] v;
    input [FW-1:0] hi;
    begin
      if (v[FW-1:0] == `OFL_CODE_OFF && v[31:FW] == {(32-FW){1'b0}})
        fit_code = `OFL_CODE_OFF;
      else
        fit_code = fit(v, `OFL_ZERO16, hi);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; taken at the first enabled access edge, which also raises pready for the answer
  // a low enable freezes the answer too, so pready may stand for several cycles
  wire access = psel && penable && clk_en;
  // one write per transfer; the answer edge must not write a second time
  wire wr = access && pwrite && !pready;
  wire unlocked = (user_group_read_select_reg == `OFL_ZERO16);
  reg mapped;

  always @*
  begin
    case (paddr)
      `OFL_UPPER_OFS, `OFL_LOWER_OFS, `OFL_HSPEED_OFS, `OFL_JOG_OFS, `OFL_START_OFS,
      `OFL_JUMP1A_OFS, `OFL_JUMP1B_OFS, `OFL_JUMP2A_OFS, `OFL_JUMP2B_OFS,
      `OFL_JUMP3A_OFS, `OFL_JUMP3B_OFS, `OFL_BASEF_OFS, `OFL_BASEF2_OFS,
      `OFL_BASEV_OFS, `OFL_GROUP_OFS, `OFL_CMD_OFS, `OFL_STATUS_OFS,
      `OFL_OUTF_OFS, `OFL_OUTBF_OFS, `OFL_OUTBV_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // writes to locked settings answer with an error when the user group is not 0; reads of them do not
  wire locked_addr = (paddr == `OFL_HSPEED_OFS) || (paddr == `OFL_BASEF2_OFS) ||
    (paddr == `OFL_BASEV_OFS) || (paddr >= `OFL_JUMP1A_OFS && paddr <= `OFL_JUMP3B_OFS);
  wire wr_ok = wr && mapped && !(locked_addr && !unlocked);

  // register write process
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_freq_limit_reg <= `OFL_UPPER_RST;
      lower_freq_limit_reg <= `OFL_LOWER_RST;
      high_speed_upper_limit_reg <= `OFL_UPPER_RST;
      jog_freq_setting_reg <= `OFL_JOG_RST;
      starting_freq_setting_reg <= `OFL_START_RST;
      for (i = 0; i < 6; i = i + 1)
        jump_band_bounds_reg[i] <= `OFL_CODE_OFF;
      primary_base_freq_reg <= `OFL_BASEF_RST;
      second_base_freq_reg <= `OFL_CODE_OFF;
      base_voltage_setting_reg <= `OFL_CODE_OFF;
      user_group_read_select_reg <= `OFL_ZERO16;
      cmd_freq_reg <= `OFL_ZERO16;
      cmd_jog_reg <= 1'b0;
      cmd_start_reg <= 1'b0;
      cmd_stall_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (paddr)
        `OFL_UPPER_OFS:
        begin
          upper_freq_limit_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F120);
          high_speed_upper_limit_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F120);
        end
        `OFL_HSPEED_OFS:
        begin
          high_speed_upper_limit_reg <= fit(pwdata, `OFL_F120, `OFL_F400);
          upper_freq_limit_reg <= fit(pwdata, `OFL_F120, `OFL_F400);
        end
        `OFL_LOWER_OFS: lower_freq_limit_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F120);
        `OFL_JOG_OFS: jog_freq_setting_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F400);
        `OFL_START_OFS: starting_freq_setting_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F400);
        `OFL_JUMP1A_OFS: jump_band_bounds_reg[0] <= fit_code(pwdata, `OFL_F400);
        `OFL_JUMP1B_OFS: jump_band_bounds_reg[1] <= fit_code(pwdata, `OFL_F400);
        `OFL_JUMP2A_OFS: jump_band_bounds_reg[2] <= fit_code(pwdata, `OFL_F400);
        `OFL_JUMP2B_OFS: jump_band_bounds_reg[3] <= fit_code(pwdata, `OFL_F400);
        `OFL_JUMP3A_OFS: jump_band_bounds_reg[4] <= fit_code(pwdata, `OFL_F400);
        `OFL_JUMP3B_OFS: jump_band_bounds_reg[5] <= fit_code(pwdata, `OFL_F400);
        `OFL_BASEF_OFS: primary_base_freq_reg <= fit(pwdata, `OFL_ZERO16, `OFL_F400);
        `OFL_BASEF2_OFS: second_base_freq_reg <= fit_code(pwdata, `OFL_F400);
        `OFL_BASEV_OFS:
        begin
          // codes pass through; other values saturate at 1000 V
          if (pwdata[FW-1:0] == `OFL_CODE_95 && pwdata[31:FW] == {(32-FW){1'b0}})
            base_voltage_setting_reg <= `OFL_CODE_95;
          else
            base_voltage_setting_reg <= fit_code(pwdata, `OFL_V1000);
        end
        `OFL_GROUP_OFS: user_group_read_select_reg <= pwdata[FW-1:0];
        `OFL_CMD_OFS:
        begin
          cmd_freq_reg <= pwdata[`OFL_CMD_FREQ_MSB:`OFL_CMD_FREQ_LSB];
          cmd_jog_reg <= pwdata[`OFL_CMD_JOG_BIT];
          cmd_start_reg <= pwdata[`OFL_CMD_START_BIT];
          cmd_stall_reg <= pwdata[`OFL_CMD_STALL_BIT];
          cmd_valid_reg <= pwdata[`OFL_CMD_VALID_BIT];
        end
        default: cmd_valid_reg <= cmd_valid_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency path: clamp, then jump bands
  reg [FW-1:0] clamped;
  reg [FW-1:0] jumped;
  reg [FW-1:0] ba;
  reg [FW-1:0] bb;
  reg [FW-1:0] lo_b;
  reg [FW-1:0] hi_b;
  reg hit_up;
  reg hit_lo;
  reg hit_jump;
  integer k;

  always @*
  begin
    hit_up = 1'b0;
    hit_lo = 1'b0;
    hit_jump = 1'b0;
    ba = `OFL_ZERO16;
    bb = `OFL_ZERO16;
    lo_b = `OFL_ZERO16;
    hi_b = `OFL_ZERO16;
    // source priority: jog, start alone, stopped, lower clamp, then the command
    if (cmd_jog_reg)
      clamped = jog_freq_setting_reg;
    else if (!cmd_valid_reg && cmd_start_reg && lower_freq_limit_reg >= starting_freq_setting_reg)
      clamped = lower_freq_limit_reg;
    else if (!cmd_start_reg)
      clamped = `OFL_ZERO16;
    else if (cmd_freq_reg < lower_freq_limit_reg && !cmd_stall_reg)
    begin
      clamped = lower_freq_limit_reg;
      hit_lo = 1'b1;
    end
    // stall lets the command through below the lower limit; the upper clamp still follows
    else
      clamped = cmd_freq_reg;
    // upper clamp applies to every source
    if (clamped > upper_freq_limit_reg)
    begin
      clamped = upper_freq_limit_reg;
      hit_up = 1'b1;
    end
    jumped = clamped;
    for (k = 0; k < 3; k = k + 1)
    begin
      ba = jump_band_bounds_reg[2*k];
      bb = jump_band_bounds_reg[2*k+1];
      lo_b = (ba < bb) ? ba : bb;
      hi_b = (ba < bb) ? bb : ba;
      // a band with either bound at 9999 is off
      if (ba != `OFL_CODE_OFF && bb != `OFL_CODE_OFF && !hit_jump &&
          clamped > lo_b && clamped < hi_b)
      begin
        hit_jump = 1'b1;
        // ties go to the lower bound; a command nearer the upper bound goes up to it
        jumped = ((clamped - lo_b) <= (hi_b - clamped)) ? lo_b : hi_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base frequency and base voltage select
  wire second_sel = second_function_input && (second_base_freq_reg != `OFL_CODE_OFF);
  wire [FW:0] supply_eff = single_phase_100v ? {supply_voltage, 1'b0} : {1'b0, supply_voltage};
  // 24 bits hold twice the widest supply times 95 with room to spare
  wire [FW+7:0] supply_95 = ({7'h00, supply_eff} * 8'd95) / 8'd100;
  reg [FW-1:0] base_v;

  // results wider than the port saturate rather than wrap
  always @*
  begin
    if (base_voltage_setting_reg == `OFL_CODE_95)
      base_v = (supply_95[FW+7:FW] != 8'h00) ? {FW{1'b1}} : supply_95[FW-1:0];
    else if (base_voltage_setting_reg == `OFL_CODE_OFF)
      base_v = supply_eff[FW] ? {FW{1'b1}} : supply_eff[FW-1:0];
    else if ({1'b0, base_voltage_setting_reg} < supply_eff)
      base_v = base_voltage_setting_reg;
    else
      base_v = supply_eff[FW] ? {FW{1'b1}} : supply_eff[FW-1:0];
  end

  // registered outputs, so the output stage never sees decode glitches
  // each output follows its settings and pins one enabled edge later
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_freq <= `OFL_ZERO16;
      out_base_freq <= `OFL_BASEF_RST;
      out_base_voltage <= `OFL_ZERO16;
      second_set_active <= 1'b0;
      up_clamp_reg <= 1'b0;
      lo_clamp_reg <= 1'b0;
      jumped_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      out_freq <= jumped;
      out_base_freq <= second_sel ? second_base_freq_reg : primary_base_freq_reg;
      out_base_voltage <= base_v;
      second_set_active <= second_function_input;
      up_clamp_reg <= hit_up;
      lo_clamp_reg <= hit_lo;
      jumped_reg <= hit_jump;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data and answer
  reg [31:0] rd;

  always @*
  begin
    case (paddr)
      `OFL_UPPER_OFS: rd = {16'h0000, upper_freq_limit_reg};
      `OFL_LOWER_OFS: rd = {16'h0000, lower_freq_limit_reg};
      `OFL_HSPEED_OFS: rd = {16'h0000, high_speed_upper_limit_reg};
      `OFL_JOG_OFS: rd = {16'h0000, jog_freq_setting_reg};
      `OFL_START_OFS: rd = {16'h0000, starting_freq_setting_reg};
      `OFL_JUMP1A_OFS: rd = {16'h0000, jump_band_bounds_reg[0]};
      `OFL_JUMP1B_OFS: rd = {16'h0000, jump_band_bounds_reg[1]};
      `OFL_JUMP2A_OFS: rd = {16'h0000, jump_band_bounds_reg[2]};
      `OFL_JUMP2B_OFS: rd = {16'h0000, jump_band_bounds_reg[3]};
      `OFL_JUMP3A_OFS: rd = {16'h0000, jump_band_bounds_reg[4]};
      `OFL_JUMP3B_OFS: rd = {16'h0000, jump_band_bounds_reg[5]};
      `OFL_BASEF_OFS: rd = {16'h0000, primary_base_freq_reg};
      `OFL_BASEF2_OFS: rd = {16'h0000, second_base_freq_reg};
      `OFL_BASEV_OFS: rd = {16'h0000, base_voltage_setting_reg};
      `OFL_GROUP_OFS: rd = {16'h0000, user_group_read_select_reg};
      `OFL_CMD_OFS: rd = {12'h000, cmd_valid_reg, cmd_stall_reg, cmd_start_reg, cmd_jog_reg, cmd_freq_reg};
      `OFL_STATUS_OFS: rd = {27'h0000000, !unlocked, jumped_reg, lo_clamp_reg, up_clamp_reg, second_set_active};
      `OFL_OUTF_OFS: rd = {16'h0000, out_freq};
      `OFL_OUTBF_OFS: rd = {16'h0000, out_base_freq};
      `OFL_OUTBV_OFS: rd = {16'h0000, out_base_voltage};
      default: rd = 32'h00000000;
    endcase
  end

  // pready rises at the first enabled access edge: one wait state per transfer while clk_en stays high, more when it is low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (!mapped || (pwrite && locked_addr && !unlocked));
      prdata <= (psel && penable && !pready && !pwrite) ? rd : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// File: tb/ofl_limiter_assertions.sv
// checker for the output frequency limiter, bound to its top module
// assumes ofl_map.vh on the include path and a single pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "ofl_map.vh"
module ofl_limiter_assertions #(
  parameter FW = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic second_function_input,
  input wire logic [FW-1:0] supply_voltage,
  input wire logic single_phase_100v,
  input wire logic [FW-1:0] out_freq,
  input wire logic [FW-1:0] out_base_freq,
  input wire logic [FW-1:0] out_base_voltage,
  input wire logic second_set_active
);
  logic bv_take;
  logic bv_wr_reg;
  logic [FW:0] dbl;
  logic [FW-1:0] bv_exp;
  ////////////////////////////////////////
  // any base voltage write, even refused, ends the default-code watch
  assign bv_take = psel && penable && pwrite && !pready && clk_en && (paddr == `OFL_BASEV_OFS);
  assign dbl = single_phase_100v ? {supply_voltage, 1'b0} : {1'b0, supply_voltage};
  assign bv_exp = dbl[FW] ? {FW{1'b1}} : dbl[FW-1:0];
  // sticky flag, conservative so it never fires wrongly
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      bv_wr_reg <= 1'b0;
    else if (bv_take)
      bv_wr_reg <= 1'b1;
  ////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("pready stood longer than one enabled cycle");
  AST_PREADY_ANSWER: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("no answer one cycle after the access edge");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside the answer");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_SECOND_COPY: assert property (clk_en |=> second_set_active == $past(second_function_input))
    else $error("second set flag does not follow its input");
  AST_OUTF_MAX: assert property (out_freq <= `OFL_F400)
    else $error("output frequency above the highest limit");
  AST_OUTBF_MAX: assert property (out_base_freq <= `OFL_F400)
    else $error("base frequency out of range");
  AST_OUTBV_DEFAULT: assert property (clk_en && !bv_wr_reg && !bv_take |=> out_base_voltage == $past(bv_exp))
    else $error("default base voltage does not track supply");
endmodule
bind ofl_limiter ofl_limiter_assertions #(.FW(FW)) u_ofl_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .second_function_input(second_function_input),
  .supply_voltage(supply_voltage), .single_phase_100v(single_phase_100v),
  .out_freq(out_freq), .out_base_freq(out_base_freq),
  .out_base_voltage(out_base_voltage), .second_set_active(second_set_active)
);
`default_nettype wire

// File: tb/ofl_stage_model.sv
// far side model: input terminal wiring and supply straps
// assumes the bench sets the request inputs on pclk edges
`timescale 1ns/1ps
`default_nettype none
module ofl_stage_model (
  input wire logic pclk,
  input wire logic [2:0] term_code,
  input wire logic sf_req,
  input wire logic [15:0] supply_req,
  input wire logic sp_req,
  output logic second_function_input,
  output logic [15:0] supply_voltage,
  output logic single_phase_100v
);
  // the terminal carries the second set only when assigned code 3
  // levels settle at the first edge, long before reset is released
  always @(posedge pclk)
  begin
    second_function_input <= sf_req && (term_code == 3'h3);
    supply_voltage <= supply_req;
    single_phase_100v <= sp_req;
  end
endmodule
`default_nettype wire

// File: tb/ofl_limiter_tb_top.sv
// self-checking bench for the output frequency limiter over apb
// assumes ofl_map.vh on the include path and the checker bound to uut
`timescale 1ns/1ps
`default_nettype none
`include "ofl_map.vh"
module ofl_limiter_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, sv;
  logic pready, pslverr, second_function_input, single_phase_100v, second_set_active;
  logic sf_req = 1'b0;
  logic sp_req = 1'b0;
  logic [2:0] term_code = 3'h3;
  logic [15:0] sup_req = 16'h0;
  logic [15:0] supply_voltage, out_freq, out_base_freq, out_base_voltage;
  logic [11:0] ja;
  logic [33:0] q[$];
  logic [33:0] note;
  int num_errors = 0;
  int check_count = 0;
  int seed = 22610;
  int i, n;
  logic [11:0] rst_a [6] = '{`OFL_UPPER_OFS, `OFL_LOWER_OFS, `OFL_BASEF_OFS, `OFL_BASEV_OFS,
    `OFL_JUMP1A_OFS, `OFL_BASEF2_OFS};
  logic [31:0] rst_v [6] = '{32'h2ee0, 32'h0, 32'h1770, 32'h270f, 32'h270f, 32'h270f};
  ofl_limiter #(.FW(16)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .second_function_input(second_function_input),
    .supply_voltage(supply_voltage), .single_phase_100v(single_phase_100v), .out_freq(out_freq),
    .out_base_freq(out_base_freq), .out_base_voltage(out_base_voltage),
    .second_set_active(second_set_active));
  ofl_stage_model u_model (.pclk(pclk), .term_code(term_code), .sf_req(sf_req), .supply_req(sup_req),
    .sp_req(sp_req), .second_function_input(second_function_input),
    .supply_voltage(supply_voltage), .single_phase_100v(single_phase_100v));
  ////////////////////////////////////////
  // clock, and a random enable so frozen cycles get exercised
  always #5 pclk = ~pclk;
  always @(posedge pclk)
    clk_en <= ($random(seed) & 32'h3) != 32'h0;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  end
  endtask
  // a frozen pready may stand on, so wait for it low before setup
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
  begin
    while (pready !== 1'b0)
      @(posedge pclk);
    q.push_back({err, w, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask
  task fcmd(input logic [31:0] c, input logic [31:0] e);
  begin
    wr(`OFL_CMD_OFS, c);
    rd(`OFL_OUTF_OFS, e);
  end
  endtask
  // pin changes need enabled edges before they show in outputs
  task settle;
  begin
    n = 0;
    while (n < 3)
    begin
      @(posedge pclk);
      if (clk_en === 1'b1)
        n++;
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  // answers match the oldest note, in issue order
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      note = q.pop_front();
      if (!note[32])
        chk(prdata, note[31:0]);
      chk({31'h0, pslverr}, {31'h0, note[33]});
    end
  initial
  begin
    #200000;
    num_errors++;
    end_sim;
  end
  ////////////////////////////////////////
  initial
  begin
    sv = $random(seed);
    sup_req = 16'h0100 | sv[15:0] & 16'h0fff;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++)
      rd(rst_a[i], rst_v[i]);
    wr(`OFL_HSPEED_OFS, 32'h7530);
    rd(`OFL_UPPER_OFS, 32'h7530);
    wr(`OFL_UPPER_OFS, 32'hc350);
    rd(`OFL_HSPEED_OFS, 32'h2ee0);
    fcmd(32'h000a3a98, 32'h2ee0);
    rd(`OFL_STATUS_OFS, 32'h2);
    wr(`OFL_LOWER_OFS, 32'h3e8);
    fcmd(32'h000a01f4, 32'h3e8);
    fcmd(32'h000e01f4, 32'h1f4);
    fcmd(32'h00010000, 32'h1f4);
    fcmd(32'h00020000, 32'h3e8);
    wr(`OFL_LOWER_OFS, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      ja = `OFL_JUMP1A_OFS + 12'h008 * i[11:0];
      wr(ja, 32'hbb8);
      wr(ja + 12'h004, 32'h7d0);
      fcmd(32'h000a0960, 32'h7d0);
      fcmd(32'h000a0a28, 32'hbb8);
      fcmd(32'h000a07d0, 32'h7d0);
      wr(ja, 32'h270f);
      fcmd(32'h000a0960, 32'h960);
    end
    wr(`OFL_BASEF2_OFS, 32'h1388);
    sf_req <= 1'b1;
    settle;
    rd(`OFL_OUTBF_OFS, 32'h1388);
    chk({31'h0, second_set_active}, 32'h1);
    // a terminal not assigned code 3 must not carry the second set
    term_code <= 3'h2;
    settle;
    rd(`OFL_OUTBF_OFS, 32'h1770);
    chk({31'h0, second_set_active}, 32'h0);
    term_code <= 3'h3;
    wr(`OFL_BASEF2_OFS, 32'h270f);
    rd(`OFL_OUTBF_OFS, 32'h1770);
    for (i = 0; i < 2; i++)
    begin
      sp_req <= i[0];
      settle;
      sv = i[0] ? {15'h0, sup_req, 1'b0} : {16'h0, sup_req};
      wr(`OFL_BASEV_OFS, 32'h22b8);
      rd(`OFL_OUTBV_OFS, sv * 32'h5f / 32'h64);
      wr(`OFL_BASEV_OFS, 32'h270f);
      rd(`OFL_OUTBV_OFS, sv);
      chk({16'h0, out_base_voltage}, sv);
      wr(`OFL_BASEV_OFS, 32'h64);
      rd(`OFL_OUTBV_OFS, 32'h64);
    end
    wr(`OFL_GROUP_OFS, 32'h1);
    apb(1'b1, `OFL_HSPEED_OFS, 32'h4e20, 1'b1);
    apb(1'b1, `OFL_BASEV_OFS, 32'h0a, 1'b1);
    rd(`OFL_HSPEED_OFS, 32'h2ee0);
    apb(1'b0, 12'h100, 32'h0, 1'b1);
    wr(`OFL_GROUP_OFS, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
